// *** rtl/ep_fifo.sv ***
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module ep_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  fifo_if.store port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  // ----------------------------------------
  // flags and handshakes
  // ----------------------------------------
  wire full = (count == (AW+1)'(DEPTH));
  wire empty = (count == '0);
  wire push = port.wr_valid & ~full;
  wire pop = port.rd_ready & ~empty;
  wire [AW-1:0] wr_ptr_inc = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [AW-1:0] rd_ptr_inc = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  assign port.wr_ready = ~full;
  assign port.rd_valid = ~empty;
  assign port.rd_data = mem[rd_ptr];

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= port.wr_data;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr_inc;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr_inc;
      end
      if (push & ~pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop & ~push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : ep_fifo

// *** rtl/fifo_if.sv ***
// valid/ready carrier between the endpoint logic and one fifo
`timescale 1ns/1ps
interface fifo_if #(parameter int WIDTH = 8);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport store
  (
    input wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data
  );
  modport user
  (
    output wr_valid, wr_data, rd_ready,
    input wr_ready, rd_valid, rd_data
  );
endinterface : fifo_if

// *** rtl/usb_endpoint_hub.sv ***
// endpoint fifo pairs, hub port decode and gated overcurrent input
`timescale 1ns/1ps
`include "usb_ep_cfg.svh"

// Functional notes
// RULE1: three endpoint pairs, each transmit plus receive
// RULE2: pair zero control only, 8/8 bytes
// RULE3: pair one 16/16 bytes, all transfer kinds
// RULE4: pair two 8/8 bytes, no isochronous
// RULE5: only pair one isochronous and dual buffered
// RULE6: four external hub ports, numbered two-five
// RULE7: embedded function sits on hub port one
// RULE8: firmware selects hub port by number, one=internal
// RULE9: overcurrent shares port3 bit0, gated by enable
// RULE10: enable set and pin low starts detection
// RULE11: enable clear ignores the shared pin
// RULE12: out-of-range endpoint index leaves fifos untouched
module usb_endpoint_hub
  import usb_ep_pkg::*;
#(
  parameter int EP0_DEPTH = `EP0_FIFO_BYTES,
  parameter int EP1_DEPTH = `EP1_FIFO_BYTES,
  parameter int EP2_DEPTH = `EP2_FIFO_BYTES
)
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] endpoint_select_index_i,
  input wire logic fw_tx_wr_i,
  input wire logic [7:0] fw_tx_data_i,
  input wire logic fw_tx_commit_i,
  input wire logic fw_rx_rd_i,
  input wire logic dual_packet_enable_i,
  input wire logic [1:0] usb_ep_i,
  input wire xfer_kind_type usb_xfer_kind_i,
  input wire logic usb_rx_wr_i,
  input wire logic [7:0] usb_rx_data_i,
  input wire logic usb_tx_rd_i,
  input wire logic usb_tx_done_i,
  input wire logic [7:0] hub_port_select_index_i,
  input wire logic [7:0] hub_status_reg_i,
  input wire logic overcurrent_input_n_i,
  output logic [7:0] fw_rd_data_o,
  output logic fw_rd_valid_o,
  output logic fw_tx_full_o,
  output logic fw_rx_empty_o,
  output logic fw_index_error_o,
  output logic [7:0] usb_tx_data_o,
  output logic usb_tx_valid_o,
  output logic usb_rx_full_o,
  output logic usb_tx_pkt_ready_o,
  output logic usb_xfer_unsupported_o,
  output logic [2:0] ep_dual_active_o,
  output logic hub_port_internal_o,
  output logic hub_port_external_o,
  output logic hub_port_invalid_o,
  output logic overcurrent_detect_o,
  output logic port3_bit0_o
);
  localparam int N = `EP_PAIR_COUNT;

  // ----------------------------------------
  // index decode
  // ----------------------------------------
  wire fw_idx_ok = (endpoint_select_index_i < 8'(N)); // RULE12
  wire [1:0] fw_sel = endpoint_select_index_i[1:0];
  wire usb_idx_ok = (usb_ep_i < 2'(N)); // RULE12
  wire [1:0] usb_sel = usb_ep_i;

  logic [N-1:0] tx_ready;
  logic [N-1:0] rx_valid;
  logic [N-1:0] tx_valid;
  logic [N-1:0] rx_ready;
  logic [N-1:0] tx_pop;
  logic [N-1:0] rx_pop;
  logic [N-1:0] pend_ok;
  logic [N-1:0] dual_on;
  logic [1:0] pend [N];
  logic [7:0] tx_rd_data [N];
  logic [7:0] rx_rd_data [N];

  // ----------------------------------------
  // endpoint pairs
  // ----------------------------------------
  for (genvar g = 0; g < N; g++)
  begin : pair
    localparam int DEPTH = (g == 0) ? EP0_DEPTH : ((g == 1) ? EP1_DEPTH : EP2_DEPTH); // RULE2
    fifo_if #(.WIDTH(`EP_DATA_WIDTH)) tx_if();
    fifo_if #(.WIDTH(`EP_DATA_WIDTH)) rx_if();
    wire fw_hit = clk_en_i & fw_idx_ok & (fw_sel == 2'(g));
    wire usb_hit = clk_en_i & usb_idx_ok & (usb_sel == 2'(g));
    // only the iso pair may hold two packets
    wire dual = dual_packet_enable_i & (2'(g) == `EP_ISO_PAIR); // RULE5
    wire [1:0] limit = dual ? `DUAL_PKT_LIMIT : `SINGLE_PKT_LIMIT; // RULE5
    wire inc = fw_hit & fw_tx_commit_i & (pend[g] < limit);
    wire dec = usb_hit & usb_tx_done_i & (pend[g] != 2'h0);

    assign pend_ok[g] = (pend[g] < limit);
    assign dual_on[g] = dual;
    assign tx_if.wr_valid = fw_hit & fw_tx_wr_i & pend_ok[g];
    assign tx_if.wr_data = fw_tx_data_i;
    assign tx_if.rd_ready = usb_hit & usb_tx_rd_i;
    assign rx_if.wr_valid = usb_hit & usb_rx_wr_i;
    assign rx_if.wr_data = usb_rx_data_i;
    assign rx_if.rd_ready = fw_hit & fw_rx_rd_i;
    assign tx_ready[g] = tx_if.wr_ready;
    assign tx_valid[g] = tx_if.rd_valid;
    assign rx_ready[g] = rx_if.wr_ready;
    assign rx_valid[g] = rx_if.rd_valid;
    assign tx_pop[g] = tx_if.rd_ready & tx_if.rd_valid;
    assign rx_pop[g] = rx_if.rd_ready & rx_if.rd_valid;
    assign tx_rd_data[g] = tx_if.rd_data;
    assign rx_rd_data[g] = rx_if.rd_data;

    ep_fifo #(.WIDTH(`EP_DATA_WIDTH), .DEPTH(DEPTH)) tx_fifo // RULE1
    (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .port(tx_if.store)
    );

    ep_fifo #(.WIDTH(`EP_DATA_WIDTH), .DEPTH(DEPTH)) rx_fifo // RULE1
    (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .port(rx_if.store)
    );

    always_ff @(posedge sys_clk_i)
    begin
      if (reset_i)
      begin
        pend[g] <= 2'h0;
      end
      else if (inc & ~dec)
      begin
        pend[g] <= pend[g] + 2'h1;
      end
      else if (dec & ~inc)
      begin
        pend[g] <= pend[g] - 2'h1;
      end
    end
  end

  // ----------------------------------------
  // transfer kind check
  // ----------------------------------------
  wire kind_iso = (usb_xfer_kind_i == XFER_ISOCHRONOUS);
  wire kind_ctl = (usb_xfer_kind_i == XFER_CONTROL);
  wire bad_pair0 = (usb_sel == `EP_CONTROL_PAIR) & ~kind_ctl; // RULE2
  wire bad_iso = kind_iso & (usb_sel != `EP_ISO_PAIR); // RULE3 RULE4
  wire next_unsupported = ~usb_idx_ok | bad_pair0 | bad_iso;

  // ----------------------------------------
  // hub port decode
  // ----------------------------------------
  wire next_port_internal = (hub_port_select_index_i == `HUB_INTERNAL_PORT); // RULE7 RULE8
  wire next_port_external = (hub_port_select_index_i >= `HUB_FIRST_EXT_PORT)
                          & (hub_port_select_index_i <= `HUB_LAST_EXT_PORT); // RULE6
  wire next_port_invalid = ~next_port_internal & ~next_port_external;

  // ----------------------------------------
  // overcurrent pin
  // ----------------------------------------
  logic ovr_meta;
  logic ovr_sync;
  wire ovr_enable = hub_status_reg_i[`OVR_ENABLE_BIT];
  wire next_ovr = ovr_enable & ~ovr_sync; // RULE10 RULE11

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      ovr_meta <= 1'b1;
      ovr_sync <= 1'b1;
    end
    else if (clk_en_i)
    begin
      ovr_meta <= overcurrent_input_n_i;
      ovr_sync <= ovr_meta;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  wire sel_ok = fw_idx_ok;
  wire next_fw_rd_valid = sel_ok & rx_pop[fw_sel];
  wire next_usb_tx_valid = usb_idx_ok & tx_pop[usb_sel];

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      fw_rd_data_o <= 8'h00;
      fw_rd_valid_o <= 1'b0;
      fw_tx_full_o <= 1'b0;
      fw_rx_empty_o <= 1'b1;
      fw_index_error_o <= 1'b0;
      usb_tx_data_o <= 8'h00;
      usb_tx_valid_o <= 1'b0;
      usb_rx_full_o <= 1'b0;
      usb_tx_pkt_ready_o <= 1'b0;
      usb_xfer_unsupported_o <= 1'b0;
      ep_dual_active_o <= 3'h0;
      hub_port_internal_o <= 1'b0;
      hub_port_external_o <= 1'b0;
      hub_port_invalid_o <= 1'b1;
      overcurrent_detect_o <= 1'b0;
      port3_bit0_o <= 1'b1;
    end
    else if (clk_en_i)
    begin
      fw_rd_valid_o <= next_fw_rd_valid;
      if (next_fw_rd_valid)
      begin
        fw_rd_data_o <= rx_rd_data[fw_sel];
      end
      fw_tx_full_o <= ~sel_ok | ~tx_ready[fw_sel] | ~pend_ok[fw_sel];
      fw_rx_empty_o <= ~sel_ok | ~rx_valid[fw_sel];
      fw_index_error_o <= ~sel_ok; // RULE12
      usb_tx_valid_o <= next_usb_tx_valid;
      if (next_usb_tx_valid)
      begin
        usb_tx_data_o <= tx_rd_data[usb_sel];
      end
      usb_rx_full_o <= ~usb_idx_ok | ~rx_ready[usb_sel];
      usb_tx_pkt_ready_o <= usb_idx_ok & (pend[usb_sel] != 2'h0) & tx_valid[usb_sel];
      usb_xfer_unsupported_o <= next_unsupported;
      ep_dual_active_o <= dual_on; // RULE5
      hub_port_internal_o <= next_port_internal;
      hub_port_external_o <= next_port_external;
      hub_port_invalid_o <= next_port_invalid;
      overcurrent_detect_o <= next_ovr; // RULE10 RULE11
      port3_bit0_o <= ovr_sync; // RULE9
    end
  end
endmodule : usb_endpoint_hub

// *** rtl/usb_ep_cfg.svh ***
// constants for the endpoint fifo and hub port logic
`ifndef USB_EP_CFG_SVH
`define USB_EP_CFG_SVH
`define EP_PAIR_COUNT 3
`define EP0_FIFO_BYTES 8
`define EP1_FIFO_BYTES 16
`define EP2_FIFO_BYTES 8
`define EP_ISO_PAIR 2'h1
`define EP_CONTROL_PAIR 2'h0
`define EP_DATA_WIDTH 8
`define SINGLE_PKT_LIMIT 2'h1
`define DUAL_PKT_LIMIT 2'h2
`define HUB_INTERNAL_PORT 8'h01
`define HUB_FIRST_EXT_PORT 8'h02
`define HUB_LAST_EXT_PORT 8'h05
`define OVR_ENABLE_BIT 7
`endif

// *** rtl/usb_ep_pkg.sv ***
// types for the endpoint fifo and hub port logic
package usb_ep_pkg;
  typedef enum logic [1:0] {
    XFER_CONTROL,
    XFER_ISOCHRONOUS,
    XFER_BULK,
    XFER_INTERRUPT
  } xfer_kind_type;
endpackage : usb_ep_pkg

// *** sim/usb_endpoint_hub_properties.sv ***
// assertion checker for the endpoint and hub block
`timescale 1ns/1ps
module usb_endpoint_hub_properties
  import usb_ep_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] endpoint_select_index_i,
  input wire logic fw_rx_rd_i,
  input wire logic [1:0] usb_ep_i,
  input wire xfer_kind_type usb_xfer_kind_i,
  input wire logic usb_tx_rd_i,
  input wire logic [7:0] hub_port_select_index_i,
  input wire logic [7:0] hub_status_reg_i,
  input wire logic overcurrent_input_n_i,
  input wire logic fw_rd_valid_o,
  input wire logic fw_index_error_o,
  input wire logic usb_tx_valid_o,
  input wire logic usb_xfer_unsupported_o,
  input wire logic [2:0] ep_dual_active_o,
  input wire logic hub_port_internal_o,
  input wire logic hub_port_external_o,
  input wire logic overcurrent_detect_o,
  input wire logic port3_bit0_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  chk_port_one: assert property (clk_en_i |=>
    hub_port_internal_o == ($past(hub_port_select_index_i) == 8'h01)) else $error("port one");
  chk_port_ext: assert property (clk_en_i |=> hub_port_external_o ==
    ($past(hub_port_select_index_i) inside {[8'h02:8'h05]})) else $error("external port");
  chk_ovr_off: assert property (clk_en_i && !hub_status_reg_i[7] |=>
    !overcurrent_detect_o) else $error("overcurrent not gated");
  chk_ovr_on: assert property ((clk_en_i && hub_status_reg_i[7] &&
    !overcurrent_input_n_i)[*3] |=> overcurrent_detect_o) else $error("overcurrent missed");
  chk_pin_follow: assert property ((clk_en_i && overcurrent_input_n_i)[*3] |=>
    port3_bit0_o) else $error("port pin level");
  chk_dual_only: assert property (!ep_dual_active_o[0] && !ep_dual_active_o[2])
    else $error("dual mode off pair one");
  chk_index_err: assert property (clk_en_i |=>
    fw_index_error_o == ($past(endpoint_select_index_i) > 8'h02)) else $error("index flag");
  chk_rd_source: assert property (fw_rd_valid_o |->
    $past(fw_rx_rd_i && clk_en_i && endpoint_select_index_i <= 8'h02)) else $error("stray read");
  chk_kind_flag: assert property (clk_en_i && ((usb_ep_i == 2'h0 &&
    usb_xfer_kind_i != XFER_CONTROL) || (usb_ep_i == 2'h2 && usb_xfer_kind_i ==
    XFER_ISOCHRONOUS)) |=> usb_xfer_unsupported_o) else $error("kind flag");
  chk_tx_source: assert property (usb_tx_valid_o |-> $past(usb_tx_rd_i))
    else $error("stray tx byte");
endmodule : usb_endpoint_hub_properties

bind usb_endpoint_hub usb_endpoint_hub_properties u_usb_endpoint_hub_properties (.*);

// *** sim/usb_endpoint_hub_tb.sv ***
// self-checking bench for the endpoint and hub block
`timescale 1ns/1ps
module usb_endpoint_hub_tb;
  logic sys_clk_i = 0, reset_i = 1, clk_en_i = 1, fw_tx_wr_i = 0, fw_tx_commit_i = 0;
  logic fw_rx_rd_i = 0, dual_packet_enable_i = 0, overcurrent_input_n_i = 1;
  logic [7:0] endpoint_select_index_i = 0, fw_tx_data_i = 0;
  logic [7:0] hub_port_select_index_i = 0, hub_status_reg_i = 0;
  logic [1:0] usb_ep_i;
  usb_ep_pkg::xfer_kind_type usb_xfer_kind_i;
  logic usb_rx_wr_i, usb_tx_rd_i, usb_tx_done_i, fw_rd_valid_o, fw_tx_full_o, fw_rx_empty_o;
  logic [7:0] usb_rx_data_i, fw_rd_data_o, usb_tx_data_o;
  logic fw_index_error_o, usb_tx_valid_o, usb_rx_full_o, usb_tx_pkt_ready_o;
  logic usb_xfer_unsupported_o, hub_port_internal_o, hub_port_external_o, hub_port_invalid_o;
  logic overcurrent_detect_o, port3_bit0_o;
  logic [2:0] ep_dual_active_o;
  logic [10:0] rows [8] = '{11'h001, 11'h00C, 11'h012, 11'h01A, 11'h022, 11'h02A, 11'h031,
    11'h7F9};
  int mismatches = 0, n_tests = 0, n;
  always #25 sys_clk_i = ~sys_clk_i;
  usb_endpoint_hub u_usb_endpoint_hub (.*);
  usb_host_model u_usb_host_model (.sys_clk_i, .usb_ep_o(usb_ep_i),
    .usb_xfer_kind_o(usb_xfer_kind_i), .usb_rx_wr_o(usb_rx_wr_i),
    .usb_rx_data_o(usb_rx_data_i), .usb_tx_rd_o(usb_tx_rd_i), .usb_tx_done_o(usb_tx_done_i));
  task automatic tick;
    @(posedge sys_clk_i);
    #2;
  endtask : tick
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial
  begin
    #100000;
    mismatches++;
    close_out();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) tick();
    check("reset", {fw_rx_empty_o, fw_tx_full_o, hub_port_invalid_o, overcurrent_detect_o,
      port3_bit0_o}, 5'h15);
    reset_i = 0;
    foreach (rows[i])
    begin
      hub_port_select_index_i = rows[i][10:3];
      repeat (2) tick();
      check("hub", {hub_port_internal_o, hub_port_external_o, hub_port_invalid_o},
        rows[i][2:0]);
    end
    for (int e = 0; e < 4; e++)
      for (int k = 0; k < 4; k++)
      begin
        u_usb_host_model.aim(e[1:0], usb_ep_pkg::xfer_kind_type'(k));
        repeat (2) tick();
        check("kind", usb_xfer_unsupported_o,
          e == 3 || (e == 0 && k != 0) || (e != 1 && k == 1));
      end
    for (int e = 0; e < 3; e++)
    begin
      u_usb_host_model.aim(e[1:0], usb_ep_pkg::XFER_CONTROL);
      repeat (2) tick();
      n = 0;
      while (usb_rx_full_o === 1'h0 && n < 20)
      begin
        u_usb_host_model.rx_push(n[7:0]);
        tick();
        n++;
      end
      check("depth", n, e == 1 ? 16 : 8);
      check("rx full", usb_rx_full_o, 1);
      endpoint_select_index_i = 8'h03;
      fw_rx_rd_i = 1;
      tick();
      fw_rx_rd_i = 0;
      tick();
      check("index", fw_index_error_o, 1);
      endpoint_select_index_i = e[7:0];
      for (int b = 0; b < n; b++)
      begin
        fw_rx_rd_i = 1;
        tick();
        check("rx data", {fw_rd_valid_o, fw_rd_data_o}, 256 + b);
        fw_rx_rd_i = 0;
        tick();
      end
      check("empty", fw_rx_empty_o, 1);
    end
    dual_packet_enable_i = 1;
    for (int e = 0; e < 2; e++)
      for (int p = 0; p < 2; p++)
      begin
        endpoint_select_index_i = e[7:0];
        fw_tx_data_i = 8'hA5;
        fw_tx_wr_i = 1;
        tick();
        fw_tx_wr_i = 0;
        fw_tx_commit_i = 1;
        tick();
        fw_tx_commit_i = 0;
        tick();
        check("limit", fw_tx_full_o, e == 0 || p == 1);
      end
    u_usb_host_model.aim(2'h1, usb_ep_pkg::XFER_ISOCHRONOUS);
    repeat (2) tick();
    check("pkt", {usb_tx_pkt_ready_o, ep_dual_active_o}, 4'hA);
    u_usb_host_model.tx_pull();
    check("tx data", {usb_tx_valid_o, usb_tx_data_o}, 9'h1A5);
    endpoint_select_index_i = 8'h00;
    u_usb_host_model.aim(2'h0, usb_ep_pkg::XFER_CONTROL);
    u_usb_host_model.tx_done();
    tick();
    check("done", {usb_tx_pkt_ready_o, fw_tx_full_o}, 0);
    overcurrent_input_n_i = 0;
    repeat (5) tick();
    check("ovr off", {overcurrent_detect_o, port3_bit0_o}, 0);
    hub_status_reg_i = 8'h80;
    repeat (2) tick();
    check("ovr on", {overcurrent_detect_o, port3_bit0_o}, 2);
    overcurrent_input_n_i = 1;
    repeat (4) tick();
    check("ovr end", {overcurrent_detect_o, port3_bit0_o}, 1);
    clk_en_i = 0;
    hub_port_select_index_i = 8'h01;
    repeat (2) tick();
    check("frozen", {hub_port_internal_o, hub_port_external_o, hub_port_invalid_o}, 1);
    clk_en_i = 1;
    tick();
    check("thawed", {hub_port_internal_o, hub_port_external_o, hub_port_invalid_o}, 4);
    close_out();
  end
endmodule : usb_endpoint_hub_tb

// *** sim/usb_host_model.sv ***
// host side model driving the usb endpoint strobes
`timescale 1ns/1ps
module usb_host_model
  import usb_ep_pkg::*;
(
  input wire logic sys_clk_i,
  output logic [1:0] usb_ep_o,
  output xfer_kind_type usb_xfer_kind_o,
  output logic usb_rx_wr_o,
  output logic [7:0] usb_rx_data_o,
  output logic usb_tx_rd_o,
  output logic usb_tx_done_o
);
  initial
  begin
    usb_ep_o = 2'h0;
    usb_xfer_kind_o = XFER_CONTROL;
    {usb_rx_wr_o, usb_tx_rd_o, usb_tx_done_o} = 3'h0;
    usb_rx_data_o = 8'h00;
  end
  task automatic aim(input logic [1:0] e, input xfer_kind_type k);
    usb_ep_o = e;
    usb_xfer_kind_o = k;
  endtask : aim
  task automatic rx_push(input logic [7:0] d);
    usb_rx_data_o = d;
    usb_rx_wr_o = 1'h1;
    @(posedge sys_clk_i);
    #2;
    usb_rx_wr_o = 1'h0;
    usb_rx_data_o = ~d;
  endtask : rx_push
  task automatic tx_pull;
    usb_tx_rd_o = 1'h1;
    @(posedge sys_clk_i);
    #2;
    usb_tx_rd_o = 1'h0;
  endtask : tx_pull
  task automatic tx_done;
    usb_tx_done_o = 1'h1;
    @(posedge sys_clk_i);
    #2;
    usb_tx_done_o = 1'h0;
  endtask : tx_done
endmodule : usb_host_model
